// ### pkg/wdsw_pkg.sv
// Package: opcodes, field layout and reset values for the swap/restart unit
package wdsw_pkg;
   localparam int OP_W = 10;
   localparam int NIB_W = 4;
   // Opcode patterns (restart: full 10-bit word; swaps: upper 6 bits only)
   localparam logic [9:0] OP_RESTART = 10'h2_A0;
   localparam logic [5:0] OP_SWAP_HI = 6'h2_D;
   localparam logic [5:0] OP_SWAPD_HI = 6'h2_F;
   // Field positions
   localparam int IMM_LSB = 0;
   localparam int HI_LSB = 4;
   // Reset values, and the Y wrap value that sets the decrement skip
   localparam logic [3:0] ACC_RST = 4'h0;
   localparam logic [3:0] REGX_RST = 4'h0;
   localparam logic [3:0] REGY_RST = 4'h0;
   localparam logic [3:0] WRAP_VAL = 4'hF;

   typedef enum logic [1:0] {
      WDSW_IDLE = 2'b00,
      WDSW_EXEC = 2'b01
   } wdsw_state_e;

   typedef struct packed {
      wdsw_state_e state;
      logic [3:0] acc;
      logic [3:0] regX;
      logic [3:0] regY;
      logic [3:0] ramWrData;
      logic ramWrEn;
      logic skipNext;
      logic flagClear;
      logic wdHalt;
      logic done;
   } wdsw_state_s;
endpackage : wdsw_pkg

// ### src/wdsw_unit.sv
// Watchdog restart and accumulator/RAM swap instruction execution
// How it works
// RL1 - Restart: flag set clears it, skips next
// RL2 - Restart after arming instruction halts watchdog
// RL3 - Swap accumulator with RAM word at pointer
// RL4 - X becomes X xor immediate after swap
// RL5 - Immediate taken from low four opcode bits
// RL6 - Decrement variant: swap, xor, Y-1, skip 15
`timescale 1ns/1ns
module wdsw_unit
   import wdsw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction from sequencer
   input wire logic instrValid,
   input wire logic [9:0] instrWord,
   input wire logic haltArmed,
   // Watchdog timer side
   input wire logic watchdog_overflow_flag,
   // RAM read data at ram_pointer
   input wire logic [3:0] ramRdData,
   // Register file loads
   input wire logic accLoad,
   input wire logic [3:0] accIn,
   input wire logic regYLoad,
   input wire logic [3:0] regYIn,
   // Results
   output logic [3:0] accOut,
   output logic [3:0] regXOut,
   output logic [3:0] regYOut,
   output logic [3:0] ramWrData,
   output logic ramWrEn,
   output logic skipNext,
   output logic flagClear,
   output logic wdHalt,
   output logic done
);

   wdsw_state_s cur;
   wdsw_state_s nxt;

   // --------------------------------------------------------------
   // Decode helpers
   // --------------------------------------------------------------
   function automatic logic isHi(input logic [9:0] w,
                                 input logic [5:0] hi);
      isHi = (w[OP_W-1:HI_LSB] == hi);
   endfunction : isHi

   function automatic logic [3:0] immOf(input logic [9:0] w);
      immOf = w[IMM_LSB +: NIB_W]; // RL5
   endfunction : immOf

   logic isRestart;
   logic isSwap;
   logic isSwapD;
   logic [3:0] yDec;

   assign isRestart = instrValid && (instrWord == OP_RESTART);
   assign isSwap = instrValid && isHi(instrWord, OP_SWAP_HI);
   assign isSwapD = instrValid && isHi(instrWord, OP_SWAPD_HI);
   assign yDec = cur.regY - 4'h1;

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      nxt = cur;
      nxt.ramWrEn = 1'b0;
      nxt.skipNext = 1'b0;
      nxt.flagClear = 1'b0;
      nxt.done = 1'b0;
      if (accLoad) begin
         nxt.acc = accIn;
      end
      if (regYLoad) begin
         nxt.regY = regYIn;
      end
      case (cur.state)
         WDSW_IDLE: begin
            if (isRestart) begin
               nxt.done = 1'b1;
               if (watchdog_overflow_flag) begin
                  nxt.flagClear = 1'b1; // RL1
                  nxt.skipNext = 1'b1; // RL1
               end
               if (haltArmed) begin
                  nxt.wdHalt = 1'b1; // RL2
               end
            end else if (isSwap || isSwapD) begin
               nxt.acc = ramRdData; // RL3
               nxt.ramWrData = cur.acc; // RL3
               nxt.ramWrEn = 1'b1; // RL3
               nxt.regX = cur.regX ^ immOf(instrWord); // RL4
               nxt.done = 1'b1;
               if (isSwapD) begin
                  nxt.regY = yDec; // RL6
                  nxt.skipNext = (yDec == WRAP_VAL); // RL6
               end
            end
         end
         default: begin
            nxt.state = WDSW_IDLE;
         end
      endcase
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{state: WDSW_IDLE, acc: ACC_RST, regX: REGX_RST,
                  regY: REGY_RST, ramWrData: 4'h0, ramWrEn: 1'b0,
                  skipNext: 1'b0, flagClear: 1'b0, wdHalt: 1'b0,
                  done: 1'b0};
      end else begin
         cur <= nxt;
      end
   end

   assign accOut = cur.acc;
   assign regXOut = cur.regX;
   assign regYOut = cur.regY;
   assign ramWrData = cur.ramWrData;
   assign ramWrEn = cur.ramWrEn;
   assign skipNext = cur.skipNext;
   assign flagClear = cur.flagClear;
   assign wdHalt = cur.wdHalt;
   assign done = cur.done;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   property p_restart_skip;
      @(posedge clk) disable iff (!rst_n)
      isRestart && watchdog_overflow_flag |=> skipNext && flagClear;
   endproperty
   a_restart_skip: assert property (p_restart_skip) // RL1
      else $error("restart with flag set did not skip and clear");

   property p_restart_noskip;
      @(posedge clk) disable iff (!rst_n)
      isRestart && !watchdog_overflow_flag |=> !skipNext && !flagClear;
   endproperty
   a_restart_noskip: assert property (p_restart_noskip) // RL1
      else $error("restart with flag clear skipped");

   property p_halt;
      @(posedge clk) disable iff (!rst_n)
      isRestart && haltArmed |=> wdHalt;
   endproperty
   a_halt: assert property (p_halt) // RL2
      else $error("watchdog not halted");

   property p_swap_acc;
      @(posedge clk) disable iff (!rst_n)
      (isSwap || isSwapD) && !accLoad |=>
         accOut == $past(ramRdData) && ramWrEn
         && ramWrData == $past(accOut);
   endproperty
   a_swap_acc: assert property (p_swap_acc) // RL3
      else $error("swap did not exchange accumulator and RAM");

   property p_swap_x;
      @(posedge clk) disable iff (!rst_n)
      (isSwap || isSwapD) |=>
         regXOut == ($past(regXOut) ^ $past(instrWord[3:0]));
   endproperty
   a_swap_x: assert property (p_swap_x) // RL4
      else $error("X not xored with immediate");

   property p_imm_zero;
      @(posedge clk) disable iff (!rst_n)
      isSwap && instrWord[3:0] == 4'h0 |=> $stable(regXOut);
   endproperty
   a_imm_zero: assert property (p_imm_zero) // RL5
      else $error("zero immediate changed X");

   property p_dec_y;
      @(posedge clk) disable iff (!rst_n)
      isSwapD && !regYLoad |=> regYOut == $past(regYOut) - 4'h1
         && skipNext == (regYOut == 4'hF);
   endproperty
   a_dec_y: assert property (p_dec_y) // RL6
      else $error("decrement variant wrong Y or skip");

   property p_swap_noskip;
      @(posedge clk) disable iff (!rst_n)
      isSwap |=> !skipNext ##1 (!ramWrEn || $past(isSwap || isSwapD));
   endproperty
   a_swap_noskip: assert property (p_swap_noskip) // RL3
      else $error("plain swap skipped or write held");

   property p_halt_sticky;
      @(posedge clk) disable iff (!rst_n)
      wdHalt |=> wdHalt;
   endproperty
   a_halt_sticky: assert property (p_halt_sticky) // RL2
      else $error("watchdog halt dropped without reset");

   property p_halt_armed_only;
      @(posedge clk) disable iff (!rst_n)
      !wdHalt && !(isRestart && haltArmed) |=> !wdHalt;
   endproperty
   a_halt_armed_only: assert property (p_halt_armed_only) // RL2
      else $error("watchdog halted without armed restart");

   property p_unmatched_quiet;
      @(posedge clk) disable iff (!rst_n)
      !(isRestart || isSwap || isSwapD) |=>
         !done && !ramWrEn && !skipNext && !flagClear;
   endproperty
   a_unmatched_quiet: assert property (p_unmatched_quiet) // RL1
      else $error("pulse without a decoded instruction");

   property p_swap_over_load;
      @(posedge clk) disable iff (!rst_n)
      (isSwap || isSwapD) && accLoad |=> accOut == $past(ramRdData);
   endproperty
   a_swap_over_load: assert property (p_swap_over_load) // RL3
      else $error("accumulator load beat the swap");

   property p_swap_keeps_y;
      @(posedge clk) disable iff (!rst_n)
      isSwap && !regYLoad |=> $stable(regYOut);
   endproperty
   a_swap_keeps_y: assert property (p_swap_keeps_y) // RL3
      else $error("plain swap changed Y");

   property p_dec_over_load;
      @(posedge clk) disable iff (!rst_n)
      isSwapD && regYLoad |=> regYOut == $past(regYOut) - 4'h1;
   endproperty
   a_dec_over_load: assert property (p_dec_over_load) // RL6
      else $error("Y load beat the decrement variant");

endmodule : wdsw_unit

// ### test/wdsw_unit_test.sv
// Self-checking testbench for the swap and watchdog restart unit
`timescale 1ns/1ns
module wdsw_unit_test;
   import wdsw_pkg::*;
   logic clk = 0;
   logic rst_n = 0;
   logic instrValid = 0;
   logic haltArmed = 0;
   logic watchdog_overflow_flag = 0;
   logic accLoad = 0;
   logic regYLoad = 0;
   logic [9:0] instrWord = 10'h000;
   logic [3:0] ramRdData = 4'h0;
   logic [3:0] accIn = 4'h0;
   logic [3:0] regYIn = 4'h0;
   logic [3:0] accOut, regXOut, regYOut, ramWrData;
   logic ramWrEn, skipNext, flagClear, wdHalt, done;
   logic [3:0] expX = 4'h0;
   int bad_count = 0;
   int checks = 0;
   wire [3:0] pulses = {ramWrEn, skipNext, flagClear, done};

   wdsw_unit DUT (.clk(clk), .rst_n(rst_n), .instrValid(instrValid),
      .instrWord(instrWord), .haltArmed(haltArmed),
      .watchdog_overflow_flag(watchdog_overflow_flag),
      .ramRdData(ramRdData), .accLoad(accLoad), .accIn(accIn),
      .regYLoad(regYLoad), .regYIn(regYIn), .accOut(accOut),
      .regXOut(regXOut), .regYOut(regYOut), .ramWrData(ramWrData),
      .ramWrEn(ramWrEn), .skipNext(skipNext), .flagClear(flagClear),
      .wdHalt(wdHalt), .done(done));

   initial forever #50 clk = ~clk;

   task chk(input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   task ld(input logic [3:0] a, input logic [3:0] y);
      @(posedge clk) #10;
      accLoad = 1;
      accIn = a;
      regYLoad = 1;
      regYIn = y;
      @(posedge clk) #10;
      accLoad = 0;
      regYLoad = 0;
   endtask : ld

   task exec(input logic [9:0] w, input logic [3:0] ram);
      @(posedge clk) #10;
      instrValid = 1;
      instrWord = w;
      ramRdData = ram;
      @(posedge clk) #10;
      instrValid = 0;
      ramRdData = ~ram;
   endtask : exec

   task t_restart;
      watchdog_overflow_flag = 1;
      exec(OP_RESTART, 4'h0);
      chk(pulses, 4'h7);
      chk({3'h0, wdHalt}, 4'h0);
      watchdog_overflow_flag = 0;
      exec(OP_RESTART, 4'h0);
      chk(pulses, 4'h1);
      exec(10'h000, 4'h0);
      chk(pulses, 4'h0);
      haltArmed = 1;
      exec(OP_RESTART, 4'h0);
      haltArmed = 0;
      chk({3'h0, wdHalt}, 4'h1);
      chk(pulses, 4'h1);
      exec(OP_RESTART, 4'h0);
      chk({3'h0, wdHalt}, 4'h1);
   endtask : t_restart

   task t_swap;
      logic [4:0] i;
      for (i = 5'h00; i < 5'h10; i++) begin
         ld(i[3:0] + 4'h3, 4'h0);
         exec({OP_SWAP_HI, i[3:0]}, ~i[3:0]);
         expX = expX ^ i[3:0];
         chk(accOut, ~i[3:0]);
         chk(ramWrData, i[3:0] + 4'h3);
         chk(pulses, 4'h9);
         chk(regXOut, expX);
         chk(regYOut, 4'h0);
      end
   endtask : t_swap

   task t_decswap(input logic [3:0] y);
      ld(4'h6, y);
      exec({OP_SWAPD_HI, 4'hA}, 4'h2);
      expX = expX ^ 4'hA;
      chk(accOut, 4'h2);
      chk(ramWrData, 4'h6);
      chk(regXOut, expX);
      chk(regYOut, y - 4'h1);
      chk(pulses, (y == 4'h0) ? 4'hD : 4'h9);
   endtask : t_decswap

   task t_collide;
      ld(4'h4, 4'h8);
      @(posedge clk) #10;
      instrValid = 1;
      instrWord = {OP_SWAPD_HI, 4'h3};
      ramRdData = 4'hC;
      accLoad = 1;
      accIn = 4'hF;
      regYLoad = 1;
      regYIn = 4'h0;
      @(posedge clk) #10;
      instrValid = 0;
      accLoad = 0;
      regYLoad = 0;
      expX = expX ^ 4'h3;
      chk(accOut, 4'hC);
      chk(ramWrData, 4'h4);
      chk(regYOut, 4'h7);
      chk(regXOut, expX);
   endtask : t_collide

   task t_reset;
      @(posedge clk) #10;
      rst_n = 0;
      @(posedge clk) #10;
      chk(accOut, ACC_RST);
      chk(ramWrData, 4'h0);
      chk(regXOut, REGX_RST);
      chk(regYOut, REGY_RST);
      chk(pulses, 4'h0);
      chk({3'h0, wdHalt}, 4'h0);
      rst_n = 1;
      expX = REGX_RST;
      exec({OP_SWAP_HI, 4'h5}, 4'h9);
      expX = expX ^ 4'h5;
      chk(accOut, 4'h9);
      chk(ramWrData, ACC_RST);
      chk(regXOut, expX);
   endtask : t_reset

   task stop_test;
      if (bad_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      #100000;
      bad_count++;
      stop_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      #10 rst_n = 1;
      t_restart();
      t_swap();
      t_decswap(4'h0);
      t_decswap(4'h1);
      t_collide();
      t_reset();
      stop_test();
   end
endmodule : wdsw_unit_test
